// ---- verilog/dcs_pkg.sv ----
// constants for the device control and status register word
package dcs_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_STAT_OFS = 8'hc8;
    localparam logic [7:0] ADDR_MASK = 8'hfc;
    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int CORR_EN_BIT = 0;
    localparam int NONFATAL_EN_BIT = 1;
    localparam int FATAL_EN_BIT = 2;
    localparam int UNSUP_EN_BIT = 3;
    localparam int RELAX_ORD_BIT = 4;
    localparam int PAYLOAD_LSB = 5;
    localparam int PAYLOAD_MSB = 7;
    localparam int EXT_TAG_BIT = 8;
    localparam int PHANTOM_BIT = 9;
    localparam int AUX_PM_BIT = 10;
    localparam int NO_SNOOP_BIT = 11;
    localparam int RD_REQ_LSB = 12;
    localparam int RD_REQ_MSB = 14;
    // ------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------
    localparam int CORR_DET_BIT = 16;
    localparam int NONFATAL_DET_BIT = 17;
    localparam int FATAL_DET_BIT = 18;
    localparam int UNSUP_DET_BIT = 19;
    localparam int AUX_DET_BIT = 20;
    localparam int PENDING_BIT = 21;
    // ------------------------------------------------------------
    // reset and fixed values
    // ------------------------------------------------------------
    localparam logic [3:0] ENABLES_RST = 4'h0;
    localparam logic [2:0] PAYLOAD_RST = 3'h0;
    localparam logic AUX_PM_RST = 1'b0;
    localparam logic [3:0] DETECT_RST = 4'h0;
    localparam logic AUX_DET_RST = 1'b1;
    localparam logic [2:0] RD_REQ_FIXED = 3'h0;
    localparam logic [2:0] PAYLOAD_CAP_SMALL = 3'h1;
    localparam logic [2:0] PAYLOAD_CAP_LARGE = 3'h2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [31:0] RDATA_RST = 32'h0010_0000;
endpackage

// ---- verilog/dcs_regs.sv ----
// device control and device status register word behind an ahb-lite slave
//
// Functional notes
// [RULE_01] bit 0 correctable reporting enable, reset 0
// [RULE_02] bit 1 non-fatal reporting enable, reset 0
// [RULE_03] bit 2 fatal reporting enable, reset 0
// [RULE_04] bit 3 unsupported request enable, reset 0
// [RULE_05] bit 4 relaxed ordering reads zero
// [RULE_06] payload field resets 0, clamps to capability
// [RULE_07] bits 8 and 9 read zero
// [RULE_08] bit 10 sticky aux power enable
// [RULE_09] bit 11 no snoop reads zero
// [RULE_10] read request size hardwired to zero
// [RULE_11] bit 16 correctable detected, write one clears
// [RULE_12] bit 17 non-fatal detected, write one clears
// [RULE_13] bit 18 fatal detected, write one clears
// [RULE_14] bit 19 unsupported detected, write one clears
// [RULE_15] bit 20 aux power present, reset 1
// [RULE_16] bit 21 transactions pending hardwired zero
// [RULE_17] capability 001 or 010 by strap
// [RULE_18] reserved bits read zero, ignore writes
// [RULE_19] detect pulse sets; set beats clear
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module dcs_regs
(
    // clock and resets
    input wire logic CLK,
    input wire logic RST,
    input wire logic PWR_ON_RST,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // port logic
    input wire logic LARGE_PAYLOAD_STRAP,
    input wire logic AUX_POWER_PRESENT,
    input wire logic CORR_ERR_PULSE,
    input wire logic NONFATAL_ERR_PULSE,
    input wire logic FATAL_ERR_PULSE,
    input wire logic UNSUP_REQ_PULSE,
    // control outputs
    output logic [3:0] REPORT_EN,
    output logic [2:0] MAX_PAYLOAD,
    output logic AUX_PM_EN
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr_pend;
        logic [3:0] enables;
        logic [2:0] payload;
        logic [3:0] detect;
        logic aux_det;
        logic [31:0] rdata;
    } dcs_state_type;

    dcs_state_type st_r;
    dcs_state_type st_nxt;
    // sticky bit lives apart: only power-on reset clears it
    logic aux_pm_r;
    logic aux_pm_nxt;

    function automatic logic [2:0] dcs_clamp(input logic [2:0] req, input logic [2:0] cap);
        return (req > cap) ? cap : req;
    endfunction

    function automatic logic [31:0] dcs_word(input dcs_state_type s, input logic aux_pm);
        logic [31:0] w;
        w = 32'h0;
        w[dcs_pkg::UNSUP_EN_BIT:dcs_pkg::CORR_EN_BIT] = s.enables;
        w[dcs_pkg::PAYLOAD_MSB:dcs_pkg::PAYLOAD_LSB] = s.payload;
        w[dcs_pkg::AUX_PM_BIT] = aux_pm;
        w[dcs_pkg::RD_REQ_MSB:dcs_pkg::RD_REQ_LSB] = dcs_pkg::RD_REQ_FIXED;
        w[dcs_pkg::UNSUP_DET_BIT:dcs_pkg::CORR_DET_BIT] = s.detect;
        w[dcs_pkg::AUX_DET_BIT] = s.aux_det;
        return w;
    endfunction

    logic addr_hit;
    logic addr_phase;
    logic [2:0] payload_cap;
    logic [3:0] det_pulse;
    logic [3:0] det_clear;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        aux_pm_nxt = aux_pm_r;
        addr_phase = HSEL && HREADY && (HTRANS == dcs_pkg::HTRANS_NONSEQ);
        addr_hit = ((HADDR[7:0] & dcs_pkg::ADDR_MASK) == dcs_pkg::CTRL_STAT_OFS)
            && (HADDR[31:8] == 24'h0);
        // [RULE_17] strap picks capability
        payload_cap = LARGE_PAYLOAD_STRAP ? dcs_pkg::PAYLOAD_CAP_LARGE
            : dcs_pkg::PAYLOAD_CAP_SMALL;
        det_pulse = {UNSUP_REQ_PULSE, FATAL_ERR_PULSE, NONFATAL_ERR_PULSE, CORR_ERR_PULSE};
        det_clear = 4'h0;
        st_nxt.aux_det = AUX_POWER_PRESENT;
        st_nxt.wr_pend = addr_phase && HWRITE && addr_hit;
        if (st_r.wr_pend)
        begin
            // [RULE_01] [RULE_02] [RULE_03] [RULE_04] enable bits
            st_nxt.enables = HWDATA[dcs_pkg::UNSUP_EN_BIT:dcs_pkg::CORR_EN_BIT];
            // [RULE_06] clamp payload
            st_nxt.payload = dcs_clamp(HWDATA[dcs_pkg::PAYLOAD_MSB:dcs_pkg::PAYLOAD_LSB],
                payload_cap);
            // [RULE_08] sticky aux enable
            aux_pm_nxt = HWDATA[dcs_pkg::AUX_PM_BIT];
            // [RULE_11] [RULE_12] [RULE_13] [RULE_14] write one clears
            det_clear = HWDATA[dcs_pkg::UNSUP_DET_BIT:dcs_pkg::CORR_DET_BIT];
        end
        // [RULE_19] set wins over clear
        st_nxt.detect = (st_r.detect & ~det_clear) | det_pulse;
        // read data is captured in the address phase so the data phase needs no wait
        if (addr_phase && !HWRITE && addr_hit)
        begin
            // [RULE_05] [RULE_07] [RULE_09] [RULE_10] [RULE_16] [RULE_18] zero fields
            st_nxt.rdata = dcs_word(st_r, aux_pm_r);
        end
        else if (addr_phase)
        begin
            st_nxt.rdata = 32'h0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            st_r.wr_pend <= 1'b0;
            st_r.enables <= dcs_pkg::ENABLES_RST;
            st_r.payload <= dcs_pkg::PAYLOAD_RST;
            st_r.detect <= dcs_pkg::DETECT_RST;
            // [RULE_15] aux present resets high
            st_r.aux_det <= dcs_pkg::AUX_DET_RST;
            st_r.rdata <= dcs_pkg::RDATA_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // [RULE_08] survives the ordinary reset
    always_ff @(posedge CLK or posedge PWR_ON_RST)
    begin
        if (PWR_ON_RST)
        begin
            aux_pm_r <= dcs_pkg::AUX_PM_RST;
        end
        else
        begin
            aux_pm_r <= aux_pm_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign HRDATA = st_r.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign REPORT_EN = st_r.enables;
    assign MAX_PAYLOAD = st_r.payload;
    assign AUX_PM_EN = aux_pm_r;
endmodule
`default_nettype wire

// ---- verif/dcs_regs_properties.sv ----
// assertions on the control and status register word
`timescale 1ns/100ps
`default_nettype none
module dcs_chk
(
    // bus
    input wire logic CLK, RST, PWR_ON_RST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP,
    input wire logic [31:0] HADDR, HWDATA, HRDATA,
    input wire logic [1:0] HTRANS,
    // port logic
    input wire logic LARGE_PAYLOAD_STRAP, AUX_POWER_PRESENT, AUX_PM_EN,
    input wire logic [3:0] REPORT_EN,
    input wire logic [2:0] MAX_PAYLOAD
);
    logic wr_q, rd_q;
    wire hit = HSEL && HREADY && HTRANS == 2'h2 && HADDR[31:2] == 30'h32;
    wire [2:0] cap = {1'b0, LARGE_PAYLOAD_STRAP, !LARGE_PAYLOAD_STRAP};
    wire [2:0] clamp = HWDATA[7:5] > cap ? cap : HWDATA[7:5];
    always_ff @(posedge CLK or posedge RST)
        if (RST)
            {wr_q, rd_q} <= 2'h0;
        else
            {wr_q, rd_q} <= {hit && HWRITE, hit && !HWRITE};
    default clocking @(posedge CLK); endclocking
    default disable iff (RST || PWR_ON_RST);
    chk_reset_state: assert property ($fell(RST) |-> !REPORT_EN && !MAX_PAYLOAD)
        else $error("controls not cleared");
    chk_never_wait: assert property (HREADYOUT) else $error("wait state");
    chk_resp_okay: assert property (!HRESP) else $error("error response");
    chk_fixed_zero: assert property ((HRDATA & 32'hffe0fb10) == 32'h0)
        else $error("fixed bit set");
    chk_enable_write: assert property (wr_q |=> REPORT_EN == $past(HWDATA[3:0]))
        else $error("enables wrong");
    chk_payload_clamp: assert property (wr_q |=> MAX_PAYLOAD == $past(clamp))
        else $error("payload wrong");
    chk_aux_write: assert property (wr_q |=> AUX_PM_EN == $past(HWDATA[10]))
        else $error("aux enable wrong");
    chk_sticky_kept: assert property ($fell(RST) |-> AUX_PM_EN == $past(AUX_PM_EN))
        else $error("sticky enable lost");
    chk_aux_seen: assert property (rd_q |-> HRDATA[20] == $past(AUX_POWER_PRESENT, 2))
        else $error("aux present wrong");
    cover property (wr_q && HWDATA[7:5] > cap);
    cover property (rd_q && HRDATA[19:16] != 4'h0);
    cover property ($rose(AUX_PM_EN));
endmodule
bind dcs_regs dcs_chk dcs_chk_inst (.CLK(CLK), .RST(RST), .PWR_ON_RST(PWR_ON_RST), .HSEL(HSEL),
    .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HADDR(HADDR),
    .HWDATA(HWDATA), .HRDATA(HRDATA), .HTRANS(HTRANS), .AUX_PM_EN(AUX_PM_EN),
    .LARGE_PAYLOAD_STRAP(LARGE_PAYLOAD_STRAP), .AUX_POWER_PRESENT(AUX_POWER_PRESENT),
    .REPORT_EN(REPORT_EN), .MAX_PAYLOAD(MAX_PAYLOAD));
`default_nettype wire

// ---- verif/dcs_regs_test.sv ----
// self-checking bench for the control and status register word
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module dcs_regs_test;
    logic clk = 0, rst = 1, por = 1, sel = 0, wr = 0, rdy, strap = 0, auxp = 1, rph = 0, aen;
    logic [31:0] adr = 0, wd = 0, rdat, d, ex;
    logic [1:0] tr = 0;
    logic [3:0] ev = 0, en, st = 0;
    logic [2:0] mp;
    logic [15:0] ctl = 0;
    logic [31:0] q[$];
    int error_cnt = 0, compares = 0, seed = 20;
    wire [2:0] cap = {1'b0, strap, !strap};
    always #5 clk = ~clk;
    dcs_regs dcs_regs_inst (.CLK(clk), .RST(rst), .PWR_ON_RST(por), .HSEL(sel), .HADDR(adr),
        .HTRANS(tr), .HWRITE(wr), .HSIZE(3'h2), .HWDATA(wd), .HREADY(rdy), .HRDATA(rdat),
        .HREADYOUT(rdy), .HRESP(), .LARGE_PAYLOAD_STRAP(strap), .AUX_POWER_PRESENT(auxp),
        .CORR_ERR_PULSE(ev[0]), .NONFATAL_ERR_PULSE(ev[1]), .FATAL_ERR_PULSE(ev[2]),
        .UNSUP_REQ_PULSE(ev[3]), .REPORT_EN(en), .MAX_PAYLOAD(mp), .AUX_PM_EN(aen));
    // one single transfer; p pulses the error inputs during its data phase
    task automatic xfer(input logic w, input logic [31:0] a, v, input logic [3:0] p);
        sel <= 1;
        tr <= 2'h2;
        adr <= a;
        wr <= w;
        do @(posedge clk); while (rdy !== 1'b1);
        if (!w)
            q.push_back(a == 32'hc8 ? {11'h0, auxp, st, ctl} : 32'h0);
        else if (a == 32'hc8)
        begin
            st = st & ~v[19:16];
            ctl = {5'h0, v[10], 2'h0, v[7:5] > cap ? cap : v[7:5], 1'b0, v[3:0]};
        end
        st = st | p;
        sel <= 0;
        tr <= 2'h0;
        wd <= v;
        ev <= p;
        rph <= !w;
        do @(posedge clk); while (rdy !== 1'b1);
        ev <= 4'h0;
        rph <= 0;
    endtask
    always @(posedge clk)
        if (rph && rdy)
        begin
            ex = q.pop_front();
            `CHK("read word", ex, rdat)
        end
    task give_verdict;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 0;
        por <= 0;
        `CHK("enables", 4'h0, en)
        `CHK("payload", 3'h0, mp)
        xfer(0, 32'hc8, 0, 0);
        xfer(1, 32'hc8, 32'hffffffff, 0);
        xfer(0, 32'hc8, 0, 0);
        strap <= 1;
        for (int i = 0; i < 8; i++)
        begin
            xfer(1, 32'hc8, i << 5, 0);
            xfer(0, 32'hc8, 0, 0);
        end
        // set, then clear racing a new set, then plain clear
        for (int i = 0; i < 4; i++)
            for (int k = 0; k < 3; k++)
            begin
                d = $random(seed);
                xfer(1, 32'hc8, (d & ~32'hf0000) | (k ? 32'h10000 << i : 0), k < 2 ? 4'h1 << i : 0);
                xfer(0, 32'hc8, 0, 0);
            end
        xfer(1, 32'hcc, 32'hffffffff, 0);
        xfer(0, 32'hcc, 0, 0);
        auxp <= 0;
        xfer(1, 32'hc8, 32'h400, 0);
        xfer(0, 32'hc8, 0, 0);
        auxp <= 1;
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        ctl = 16'h0400;
        st = 0;
        xfer(0, 32'hc8, 0, 0);
        `CHK("aux enable kept", 1'b1, aen)
        por <= 1;
        @(posedge clk);
        por <= 0;
        @(negedge clk);
        `CHK("aux enable cleared", 1'b0, aen)
        ctl = 0;
        xfer(0, 32'hc8, 0, 0);
        @(posedge clk);
        give_verdict;
    end
    initial
    begin
        #20000;
        error_cnt++;
        give_verdict;
    end
endmodule
`default_nettype wire
